// >>> src/cts_tx_sched.sv
`timescale 1ns/1ps

// Link-domain end: holds the frame for the engine and returns its result
module cts_link
  import cts_pkg::*;
(
  input  wire logic         link_clk,
  input  wire logic         srst,
  input  wire logic         core_req,
  input  wire cts_frame_t   core_frame,
  output logic              link_ack,
  output cts_result_t       link_result,
  output logic              eng_frame_valid,
  output cts_frame_t        eng_frame,
  input  wire logic         eng_result_valid,
  input  wire cts_result_t  eng_result
);

  cts_link_state_t q;
  cts_link_state_t n;

  // Four-phase handshake toward the core domain
  always_comb begin
    n        = q;
    n.rst_s1 = srst;
    n.rst_s2 = q.rst_s1;
    n.req_s1 = core_req;
    n.req_s2 = q.req_s1;
    if (q.rst_s2) begin
      n.fvalid = 1'b0;
      n.ack    = 1'b0;
      n.result = CTS_RES_OK;
      n.frame  = '0;
    end else begin
      // Frame is stable in the core while its request stands
      if (q.req_s2 && !q.ack && !q.fvalid) begin
        n.frame  = core_frame;
        n.fvalid = 1'b1;
      end
      if (q.fvalid && eng_result_valid) begin
        n.fvalid = 1'b0;
        n.result = eng_result;
        n.ack    = 1'b1;
      end
      if (q.ack && !q.req_s2) begin
        n.ack = 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    q <= n;
  end

  assign link_ack        = q.ack;
  assign link_result     = q.result;
  assign eng_frame_valid = q.fvalid;
  assign eng_frame       = q.frame;

endmodule

// Transmit buffers, request sources and priority scheduler
module cts_tx_sched
  import cts_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         link_clk,
  input  wire logic [6:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_we,
  output logic [7:0]        reg_rdata,
  input  wire logic [2:0]   send_request_cmd,
  input  wire logic [2:0]   request_pin_n,
  input  wire logic         cfg_mode,
  input  wire logic         single_attempt_mode,
  input  wire logic         abort_all_request,
  input  wire logic [2:0]   tx_done_int_enable,
  input  wire logic         message_error_int_enable,
  input  wire logic [2:0]   tx_done_clr,
  input  wire logic         message_error_clr,
  output logic [2:0]        tx_done_flag,
  output logic              message_error_flag,
  output logic              irq_out,
  input  wire logic         eng_bus_idle,
  output logic              eng_frame_valid,
  output cts_frame_t        eng_frame,
  input  wire logic         eng_result_valid,
  input  wire cts_result_t  eng_result
);

  cts_core_state_t q;
  cts_core_state_t n;
  logic            link_ack;
  cts_result_t     link_result;

  cts_link u_link (
    .link_clk         (link_clk),
    .srst             (srst),
    .core_req         (q.req),
    .core_frame       (q.frame),
    .link_ack         (link_ack),
    .link_result      (link_result),
    .eng_frame_valid  (eng_frame_valid),
    .eng_frame        (eng_frame),
    .eng_result_valid (eng_result_valid),
    .eng_result       (eng_result)
  );

  // Address decode of the buffer window
  logic       in_buf;
  logic [1:0] a_buf;
  logic [3:0] a_off;
  logic [2:0] a_hi;
  always_comb begin
    a_hi   = reg_addr[6:4] - BUF_BASE_HI;
    a_buf  = a_hi[1:0];
    a_off  = reg_addr[3:0];
    in_buf = (reg_addr >= ADDR_TX_BUFFER0_CONTROL) && (reg_addr[6:4] <= ADDR_TX_BUFFER2_CONTROL[6:4])
             && (a_off <= OFF_LAST);
  end

  // Main next-state logic
  logic [2:0] fall;
  logic       fail;
  logic       found;
  logic [1:0] win;
  logic [1:0] best;
  logic [3:0] len;
  logic [3:0] boff;
  always_comb begin
    n     = q;
    fail  = 1'b0;
    found = 1'b0;
    win   = 2'h0;
    best  = PRIO_RST;
    len   = 4'h0;
    boff  = 4'h0;

    // Synchronisers: pins, bus idle, link acknowledge
    n.pin_s1  = request_pin_n;
    n.pin_s2  = q.pin_s1;
    n.pin_s3  = q.pin_s2;
    n.idle_s1 = eng_bus_idle;
    n.idle_s2 = q.idle_s1;
    n.ack_s1  = link_ack;
    n.ack_s2  = q.ack_s1;
    fall      = q.pin_s3 & ~q.pin_s2 & q.request_pin_function;

    // Host clears of the done and error flags
    n.tx_done_flag       = q.tx_done_flag & ~tx_done_clr;
    n.message_error_flag = q.message_error_flag & ~message_error_clr;

    // Host register writes
    if (reg_we) begin
      if (in_buf) begin
        if (a_off == OFF_CTRL) begin
          n.tx_priority[a_buf]      = reg_wdata[CTRL_PRIO_LSB +: 2];
          n.transmit_request[a_buf] = reg_wdata[CTRL_REQ_BIT];
          if (reg_wdata[CTRL_REQ_BIT] && !q.transmit_request[a_buf]) begin
            n.abort_flag[a_buf]            = 1'b0;
            n.lost_arbitration_flag[a_buf] = 1'b0;
            n.tx_error_flag[a_buf]         = 1'b0;
          end
        end else begin
          boff = a_off - 4'h1;
          if (a_off == OFF_SIDL) begin
            n.body[a_buf][boff] = reg_wdata & SIDL_MASK;
          end else if (a_off == OFF_DLC) begin
            n.body[a_buf][boff] = reg_wdata & DLC_MASK;
          end else begin
            n.body[a_buf][boff] = reg_wdata;
          end
        end
      end else if (reg_addr == ADDR_REQUEST_PIN_CONTROL_STATUS && cfg_mode) begin
        n.request_pin_function = reg_wdata[PIN_FUNC_LSB +: 3];
      end
    end

    // Pin edges and send command; a set wins over a same-cycle host-write clear
    for (int b = 0; b < NUM_BUF; b++) begin
      if (fall[b] || send_request_cmd[b]) begin
        n.transmit_request[b] = 1'b1;
        if (!q.transmit_request[b]) begin
          n.abort_flag[b]            = 1'b0;
          n.lost_arbitration_flag[b] = 1'b0;
          n.tx_error_flag[b]         = 1'b0;
        end
      end
    end

    // Abort-all takes every pending buffer not in flight
    if (abort_all_request) begin
      for (int b = 0; b < NUM_BUF; b++) begin
        if (q.transmit_request[b] && !(q.busy && q.sel == 2'(b))) begin
          n.transmit_request[b] = 1'b0;
          n.abort_flag[b]       = 1'b1;
        end
      end
    end

    // Result of a frame in flight
    if (q.req && q.ack_s2) begin
      n.req = 1'b0;
      unique case (link_result)
        CTS_RES_OK: begin
          n.transmit_request[q.sel] = 1'b0;
          n.tx_done_flag[q.sel]     = 1'b1;
        end
        CTS_RES_ERROR: begin
          n.tx_error_flag[q.sel] = 1'b1;
          n.message_error_flag   = 1'b1;
          fail                   = 1'b1;
        end
        CTS_RES_LOST: begin
          n.lost_arbitration_flag[q.sel] = 1'b1;
          fail                           = 1'b1;
        end
        default: begin
          n.tx_error_flag[q.sel] = 1'b1;
          n.message_error_flag   = 1'b1;
          fail                   = 1'b1;
        end
      endcase
      // Failure retries unless single-attempt or abort-all
      if (fail && (single_attempt_mode || abort_all_request)) begin
        n.transmit_request[q.sel] = 1'b0;
        n.abort_flag[q.sel]       = 1'b1;
      end
    end

    // Handshake finished once the link drops its acknowledge
    if (q.busy && !q.req && !q.ack_s2) begin
      n.busy = 1'b0;
    end

    // Pick the winner before start-of-frame, only while the bus is free
    for (int b = 0; b < NUM_BUF; b++) begin
      if (q.transmit_request[b] && (!found || q.tx_priority[b] >= best)) begin
        found = 1'b1;
        best  = q.tx_priority[b];
        win   = 2'(b);
      end
    end
    if (!q.busy && !abort_all_request && q.idle_s2 && found) begin
      n.busy                = 1'b1;
      n.req                 = 1'b1;
      n.sel                 = win;
      len                   = q.body[win][4][3:0];
      n.frame.buf_idx       = win;
      n.frame.id_bytes      = {q.body[win][0], q.body[win][1], q.body[win][2], q.body[win][3]};
      n.frame.length_byte   = q.body[win][4];
      n.frame.payload_count = (len > LEN_MAX) ? LEN_MAX : len;
      for (int k = 0; k < MAX_PAYLOAD; k++) begin
        n.frame.payload_bytes[k] = q.body[win][5 + k];
      end
    end

    // Read data, one cycle behind the address
    n.rdata = 8'h00;
    if (in_buf) begin
      if (a_off == OFF_CTRL) begin
        n.rdata[CTRL_ABORT_BIT]        = q.abort_flag[a_buf];
        n.rdata[CTRL_LOST_BIT]         = q.lost_arbitration_flag[a_buf];
        n.rdata[CTRL_ERR_BIT]          = q.tx_error_flag[a_buf];
        n.rdata[CTRL_REQ_BIT]          = q.transmit_request[a_buf];
        n.rdata[CTRL_PRIO_LSB +: 2]    = q.tx_priority[a_buf];
      end else begin
        boff    = a_off - 4'h1;
        n.rdata = q.body[a_buf][boff];
      end
    end else if (reg_addr == ADDR_REQUEST_PIN_CONTROL_STATUS) begin
      n.rdata[PIN_FUNC_LSB +: 3]  = q.request_pin_function;
      n.rdata[PIN_LEVEL_LSB +: 3] = q.pin_s2 & ~q.request_pin_function;
    end

    // Interrupt output from enabled flags
    n.irq = |(n.tx_done_flag & tx_done_int_enable) |
            (n.message_error_flag & message_error_int_enable);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata          = q.rdata;
  assign tx_done_flag       = q.tx_done_flag;
  assign message_error_flag = q.message_error_flag;
  assign irq_out            = q.irq;

endmodule

// >>> src/cts_pkg.sv
package cts_pkg;

  // Buffer geometry
  localparam int NUM_BUF      = 3;
  localparam int BODY_BYTES   = 13;
  localparam int MAX_PAYLOAD  = 8;

  // Register addresses and in-buffer offsets
  localparam logic [6:0] ADDR_REQUEST_PIN_CONTROL_STATUS = 7'h0d;
  localparam logic [6:0] ADDR_TX_BUFFER0_CONTROL         = 7'h30;
  localparam logic [6:0] ADDR_TX_BUFFER1_CONTROL         = 7'h40;
  localparam logic [6:0] ADDR_TX_BUFFER2_CONTROL         = 7'h50;
  localparam logic [2:0] BUF_BASE_HI                     = 3'h3;
  localparam logic [3:0] OFF_CTRL                        = 4'h0;
  localparam logic [3:0] OFF_SIDL                        = 4'h2;
  localparam logic [3:0] OFF_DLC                         = 4'h5;
  localparam logic [3:0] OFF_LAST                        = 4'hd;

  // Control byte fields
  localparam int CTRL_ABORT_BIT = 6;
  localparam int CTRL_LOST_BIT  = 5;
  localparam int CTRL_ERR_BIT   = 4;
  localparam int CTRL_REQ_BIT   = 3;
  localparam int CTRL_PRIO_LSB  = 0;

  // Request pin control fields
  localparam int PIN_FUNC_LSB  = 0;
  localparam int PIN_LEVEL_LSB = 3;

  // Writable-bit masks of identifier low and length bytes
  localparam logic [7:0] SIDL_MASK   = 8'heb;
  localparam logic [7:0] DLC_MASK    = 8'h4f;
  localparam logic [3:0] LEN_MAX     = 4'h8;

  // Values after reset
  localparam logic [1:0] PRIO_RST     = 2'h0;
  localparam logic [2:0] PIN_FUNC_RST = 3'h0;

  typedef enum logic [1:0] {
    CTS_RES_OK    = 2'b00,
    CTS_RES_ERROR = 2'b01,
    CTS_RES_LOST  = 2'b10
  } cts_result_t;

  // Frame handed to the protocol engine
  typedef struct packed {
    logic [1:0]            buf_idx;
    logic [3:0][7:0]       id_bytes;
    logic [7:0]            length_byte;
    logic [3:0]            payload_count;
    logic [7:0][7:0]       payload_bytes;
  } cts_frame_t;

  // Core-domain state
  typedef struct packed {
    logic [2:0][12:0][7:0] body;
    logic [2:0][1:0]       tx_priority;
    logic [2:0]            transmit_request;
    logic [2:0]            abort_flag;
    logic [2:0]            lost_arbitration_flag;
    logic [2:0]            tx_error_flag;
    logic [2:0]            tx_done_flag;
    logic                  message_error_flag;
    logic [2:0]            request_pin_function;
    logic [2:0]            pin_s1;
    logic [2:0]            pin_s2;
    logic [2:0]            pin_s3;
    logic                  idle_s1;
    logic                  idle_s2;
    logic                  ack_s1;
    logic                  ack_s2;
    logic                  req;
    logic                  busy;
    logic [1:0]            sel;
    cts_frame_t            frame;
    logic [7:0]            rdata;
    logic                  irq;
  } cts_core_state_t;

  // Link-domain state
  typedef struct packed {
    logic                  rst_s1;
    logic                  rst_s2;
    logic                  req_s1;
    logic                  req_s2;
    logic                  fvalid;
    logic                  ack;
    cts_result_t           result;
    cts_frame_t            frame;
  } cts_link_state_t;

endpackage

// >>> sim/cts_tx_sched_properties.sv
`timescale 1ns/1ps
// Port checks of the transmit scheduler
module cts_chk
  import cts_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       link_clk,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] tx_done_int_enable,
  input wire logic       message_error_int_enable,
  input wire logic [2:0] tx_done_clr,
  input wire logic [2:0] tx_done_flag,
  input wire logic       message_error_flag,
  input wire logic       irq_out,
  input wire logic       eng_frame_valid,
  input wire cts_frame_t eng_frame,
  input wire logic       eng_result_valid
);
  logic irq_c;
  // Any enabled flag raised
  assign irq_c = |(tx_done_flag & tx_done_int_enable) | (message_error_flag & message_error_int_enable);
  a_irq_on: assert property (@(posedge core_clk) disable iff (srst)
    irq_c && $past(irq_c) |-> irq_out) else $error("irq low with flag set");
  a_irq_off: assert property (@(posedge core_clk) disable iff (srst)
    !irq_c && $past(!irq_c) |-> !irq_out) else $error("irq high without flag");
  a_done_sticky: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> (($past(tx_done_flag) & ~$past(tx_done_clr) & ~tx_done_flag) == 3'h0))
    else $error("done flag lost");
  a_ctrl_unimpl: assert property (@(posedge core_clk) disable iff (srst)
    reg_addr inside {7'h30, 7'h40, 7'h50} |=> reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("control unused bit set");
  a_pin_level: assert property (@(posedge core_clk) disable iff (srst)
    reg_addr == 7'h0d |=> (reg_rdata[5:3] & reg_rdata[2:0]) == 3'h0 && reg_rdata[7:6] == 2'h0)
    else $error("pin level in request mode");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (srst)
    reg_addr inside {7'h00, 7'h3e, 7'h3f} |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_length_mask: assert property (@(posedge core_clk) disable iff (srst)
    reg_addr inside {7'h35, 7'h45, 7'h55} |=> (reg_rdata & 8'hb0) == 8'h00)
    else $error("length byte unused bits");
  a_frame_stable: assert property (@(posedge link_clk) disable iff (srst)
    eng_frame_valid && $past(eng_frame_valid) |-> $stable(eng_frame)) else $error("frame moved");
  a_frame_hold: assert property (@(posedge link_clk) disable iff (srst)
    eng_frame_valid && !eng_result_valid |=> eng_frame_valid) else $error("frame dropped");
  a_payload_cap: assert property (@(posedge link_clk) disable iff (srst)
    eng_frame_valid |-> eng_frame.payload_count <= 4'h8) else $error("payload above eight");
endmodule

bind cts_tx_sched cts_chk chk_u (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .tx_done_int_enable(tx_done_int_enable),
  .message_error_int_enable(message_error_int_enable), .tx_done_clr(tx_done_clr),
  .tx_done_flag(tx_done_flag), .message_error_flag(message_error_flag), .irq_out(irq_out),
  .eng_frame_valid(eng_frame_valid), .eng_frame(eng_frame), .eng_result_valid(eng_result_valid));

// >>> sim/cts_engine_model.sv
`timescale 1ns/1ps
// Protocol engine stand-in on the link clock
module cts_engine_model
  import cts_pkg::*;
(
  input wire logic        link_clk,
  input wire logic        srst,
  input wire logic        bus_free,
  input wire cts_result_t res_sel,
  output logic            eng_bus_idle,
  input wire logic        eng_frame_valid,
  output logic            eng_result_valid,
  output cts_result_t     eng_result
);
  logic [1:0] wait_q;
  logic       done_q;
  // Bus state reported to the scheduler
  assign eng_bus_idle = bus_free;
  // Answer each offered frame once, three link cycles later
  always @(posedge link_clk) begin
    if (srst) begin
      wait_q <= 2'h0;
      done_q <= 1'b0;
      eng_result_valid <= 1'b0;
      eng_result <= CTS_RES_LOST;
    end else if (eng_result_valid) begin
      eng_result_valid <= 1'b0;
      eng_result <= cts_result_t'(~eng_result); // Stale result toggles
    end else if (!eng_frame_valid) begin
      wait_q <= 2'h0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == 2'h2) begin
        eng_result_valid <= 1'b1;
        eng_result <= res_sel;
        done_q <= 1'b1;
      end
    end
  end
endmodule

// >>> sim/cts_tx_sched_tb.sv
`timescale 1ns/1ps
module cts_tx_sched_tb import cts_pkg::*;;
  logic        core_clk, link_clk, srst, we, cfg, sam, aar, mee, mec, bfree, efv, erv, eidle, mef, irq;
  logic [6:0]  addr;
  logic [7:0]  wd, rdat;
  logic [2:0]  cmd, pin_n, tde, tdc, tdf;
  cts_frame_t  efr;
  cts_result_t ers, rsel;
  int          num_errors, cmp_count, nlog, cyc, n0;
  logic [1:0]  idx_log [0:31];
  logic [3:0]  pc_log [0:31];
  logic [7:0]  id_log [0:31];
  logic [7:0]  pl_log [0:31];

  cts_tx_sched dut_u (.core_clk(core_clk), .srst(srst), .link_clk(link_clk), .reg_addr(addr),
    .reg_wdata(wd), .reg_we(we), .reg_rdata(rdat), .send_request_cmd(cmd), .request_pin_n(pin_n),
    .cfg_mode(cfg), .single_attempt_mode(sam), .abort_all_request(aar), .tx_done_int_enable(tde),
    .message_error_int_enable(mee), .tx_done_clr(tdc), .message_error_clr(mec), .tx_done_flag(tdf),
    .message_error_flag(mef), .irq_out(irq), .eng_bus_idle(eidle), .eng_frame_valid(efv),
    .eng_frame(efr), .eng_result_valid(erv), .eng_result(ers));
  cts_engine_model eng_u (.link_clk(link_clk), .srst(srst), .bus_free(bfree), .res_sel(rsel),
    .eng_bus_idle(eidle), .eng_frame_valid(efv), .eng_result_valid(erv), .eng_result(ers));

  // Clocks
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // Log each answered frame
  always @(posedge link_clk) begin
    if (efv === 1'b1 && erv === 1'b1 && nlog < 32) begin
      idx_log[nlog] = efr.buf_idx;
      pc_log[nlog] = efr.payload_count;
      id_log[nlog] = efr.id_bytes[3];
      pl_log[nlog] = efr.payload_bytes[0];
      nlog++;
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    tick(1);
    addr = a;
    wd = d;
    we = 1'b1;
    tick(1);
    we = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    tick(1);
    addr = a;
    tick(1);
    chk(rdat, exp);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {we, cfg, sam, aar, mec, bfree, addr, wd, cmd, tdc} = '0;
    {num_errors, cmp_count, nlog, cyc} = '0;
    {pin_n, tde, mee, srst} = 8'hff;
    rsel = CTS_RES_OK;
    tick(4);
    srst = 1'b0;
    for (int i = 0; i < 3; i++) rd(7'h30 + 7'(i * 16), 8'h00);
    rd(7'h0d, 8'h38);
    rd(7'h3e, 8'h00);
    // Identifier, length and first payload byte of each idle buffer
    for (int b = 0; b < 3; b++) begin
      wr(7'h31 + 7'(b * 16), 8'h11 * 8'(b + 1));
      wr(7'h35 + 7'(b * 16), 8'h02);
      wr(7'h36 + 7'(b * 16), 8'ha0 + 8'(b));
    end
    wr(7'h32, 8'hff);
    rd(7'h32, 8'heb);
    wr(7'h55, 8'hff);
    rd(7'h55, 8'h4f);
    wr(7'h30, 8'hff);
    rd(7'h30, 8'h0b);
    tick(30);
    chk({7'h0, efv}, 8'h00);
    wr(7'h30, 8'h03);
    rd(7'h30, 8'h03);
    wr(7'h30, 8'h0b);
    wr(7'h40, 8'h0a);
    wr(7'h50, 8'h0a);
    bfree = 1'b1;
    for (int i = 0; i < 400 && tdf !== 3'h7; i++) tick(1);
    chk({6'h0, idx_log[0]}, 8'h00);
    chk({6'h0, idx_log[1]}, 8'h02);
    chk({6'h0, idx_log[2]}, 8'h01);
    chk({4'h0, pc_log[0]}, 8'h02);
    chk({4'h0, pc_log[1]}, 8'h08);
    chk(id_log[0], 8'h11);
    chk(id_log[1], 8'h33);
    chk(pl_log[1], 8'ha2);
    tick(2);
    chk({4'h0, irq, tdf}, 8'h0f);
    // Interrupt follows its enable
    tde = 3'h0;
    tick(2);
    chk({7'h0, irq}, 8'h00);
    tde = 3'h7;
    rd(7'h40, 8'h02);
    tdc = 3'h7;
    tick(1);
    tdc = 3'h0;
    tick(2);
    chk({7'h0, irq}, 8'h00);
    sam = 1'b1;
    rsel = CTS_RES_ERROR;
    wr(7'h40, 8'h08);
    for (int i = 0; i < 200 && mef !== 1'b1; i++) tick(1);
    tick(10);
    rd(7'h40, 8'h50);
    chk({6'h0, mef, irq}, 8'h03);
    mec = 1'b1;
    tick(1);
    mec = 1'b0;
    rsel = CTS_RES_LOST;
    wr(7'h40, 8'h08);
    tick(60);
    rd(7'h40, 8'h60);
    sam = 1'b0;
    n0 = nlog;
    wr(7'h40, 8'h08);
    tick(150);
    bfree = 1'b0;
    tick(60);
    rd(7'h40, 8'h28);
    chk({7'h0, nlog - n0 > 2}, 8'h01);
    aar = 1'b1;
    tick(4);
    aar = 1'b0;
    rd(7'h40, 8'h60);
    wr(7'h0d, 8'h07);
    rd(7'h0d, 8'h38);
    cfg = 1'b1;
    wr(7'h0d, 8'h01);
    rd(7'h0d, 8'h31);
    pin_n = 3'b100;
    tick(8);
    rd(7'h30, 8'h0b);
    rd(7'h40, 8'h60);
    rd(7'h0d, 8'h21);
    wr(7'h30, 8'h03);
    tick(8);
    rd(7'h30, 8'h03);
    cmd = 3'b100;
    tick(1);
    cmd = 3'b000;
    rd(7'h50, 8'h0a);
    // Bus error without single attempt keeps the request
    rsel = CTS_RES_ERROR;
    bfree = 1'b1;
    for (int i = 0; i < 200 && mef !== 1'b1; i++) tick(1);
    bfree = 1'b0;
    tick(60);
    rd(7'h50, 8'h1a);
    chk({6'h0, mef, irq}, 8'h03);
    // Abort-all while a frame is in flight: aborted once it fails
    bfree = 1'b1;
    for (int i = 0; i < 200 && efv !== 1'b1; i++) tick(1);
    aar = 1'b1;
    tick(60);
    aar = 1'b0;
    rd(7'h50, 8'h52);
    summarize();
  end
endmodule
